/* File: rtl/chs_bcd_step.sv */
// BCD seconds increment, 00..59 with wrap carry
`timescale 1ns/1ps
`default_nettype none
module chs_bcd_step
  import chs_pkg::*;
(
  input wire logic [6:0] cur, // Current BCD seconds
  output logic [6:0] nxt, // Incremented BCD seconds
  output logic wrap // Wrapped 59 to 00
);

  always_comb begin
    wrap = 1'b0;
    if (cur[3:0] >= CHS_UNITS_MAX) begin
      if (cur[6:4] >= CHS_TENS_MAX) begin
        nxt = 7'h00;
        wrap = 1'b1;
      end else begin
        nxt = {cur[6:4] + 3'h1, 4'h0};
      end
    end else begin
      nxt = {cur[6:4], cur[3:0] + 4'h1};
    end
  end

endmodule // chs_bcd_step
`default_nettype wire

/* File: rtl/chs_calendar_ctrl.sv */
// Calendar control register, hold handshake, alarm flags and seconds
`timescale 1ns/1ps
`default_nettype none
module chs_calendar_ctrl
  import chs_pkg::*;
(
  input wire logic clk_sys, // 20 MHz system clock
  input wire logic rst_n, // Retention reset, low, sync
  input wire logic ce, // Clock enable, freezes all state
  input wire logic cal_tick, // One pulse per calendar clock
  input wire logic clock_run_enable, // Calendar counting enable
  input wire logic standby_exit, // Pulse on leaving standby
  input wire logic alarm_match, // Alarm comparator equal, level
  input wire logic periodic_event, // Constant-period event pulse
  input wire logic trim_tick_event, // Correction timing pulse
  input wire logic [19:0] bus_addr, // Register byte address
  input wire logic bus_wr, // Write strobe
  input wire logic bus_rd, // Read strobe
  input wire logic [7:0] bus_wdata, // Write data
  output logic [7:0] bus_rdata, // Read data, one cycle later
  output logic calendar_irq, // Alarm/periodic interrupt pulse
  output logic trim_tick_irq, // Correction tick interrupt pulse
  output logic hold_ack_flag, // Hold acknowledged
  output logic [6:0] sec_value, // Current BCD seconds
  output logic sec_carry // Seconds wrapped pulse
);

  chs_state_type state_reg;
  chs_state_type state_next;

  logic wr_ctrl;
  logic wr_sec;
  logic presc_ovf;
  logic freeze;
  logic [6:0] sec_inc;
  logic sec_wrap;
  logic [7:0] ctrl_view;

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  chs_prescaler u_presc (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .tick(cal_tick),
    .run(clock_run_enable),
    .clear(wr_sec),
    .ovf(presc_ovf)
  );

  chs_bcd_step u_step (
    .cur(state_reg.sec),
    .nxt(sec_inc),
    .wrap(sec_wrap)
  );

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  assign wr_ctrl = bus_wr && (bus_addr == CHS_CTRL_ADDR);
  assign wr_sec = bus_wr && (bus_addr == CHS_SEC_ADDR);
  assign freeze = state_reg.hold_req || state_reg.hold_ack;

  always_comb begin
    ctrl_view = CHS_CTRL_RESET;
    ctrl_view[CHS_ALARM_MATCH_ENABLE_BIT] = state_reg.alarm_match_enable;
    ctrl_view[CHS_ALARM_IRQ_ENABLE_BIT] = state_reg.alarm_irq_enable;
    ctrl_view[CHS_TRIM_TICK_IRQ_ENABLE_BIT] = state_reg.trim_tick_irq_enable;
    ctrl_view[CHS_ALARM_HIT_FLAG_BIT] = state_reg.alarm_hit_flag;
    ctrl_view[CHS_PERIODIC_HIT_FLAG_BIT] = state_reg.periodic_hit_flag;
    ctrl_view[CHS_ACK_BIT] = state_reg.hold_ack;
    ctrl_view[CHS_REQ_BIT] = state_reg.hold_req;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.irq = 1'b0;
    state_next.tit = 1'b0;
    state_next.sec_carry = 1'b0;
    state_next.run_d = clock_run_enable;

    // Register reads
    if (bus_rd) begin
      if (bus_addr == CHS_CTRL_ADDR) begin
        state_next.rdata = ctrl_view;
      end else if (bus_addr == CHS_SEC_ADDR) begin
        state_next.rdata = {1'b0, state_reg.sec};
      end else begin
        state_next.rdata = 8'h00;
      end
    end

    // Control writes; bit 2 and the ack bit are not writable
    if (wr_ctrl) begin
      state_next.alarm_match_enable = bus_wdata[CHS_ALARM_MATCH_ENABLE_BIT];
      state_next.alarm_irq_enable = bus_wdata[CHS_ALARM_IRQ_ENABLE_BIT];
      state_next.trim_tick_irq_enable = bus_wdata[CHS_TRIM_TICK_IRQ_ENABLE_BIT];
      state_next.hold_req = bus_wdata[CHS_REQ_BIT];
      if (!bus_wdata[CHS_ALARM_HIT_FLAG_BIT]) begin
        state_next.alarm_hit_flag = 1'b0;
      end
      if (!bus_wdata[CHS_PERIODIC_HIT_FLAG_BIT]) begin
        state_next.periodic_hit_flag = 1'b0;
      end
    end

    // Seconds writes land in the buffer first
    if (wr_sec) begin
      state_next.sec_buf = bus_wdata[6:0];
      state_next.wr_pend = 1'b1;
      state_next.carry_pend = 1'b0;
    end else if (presc_ovf) begin
      state_next.carry_pend = 1'b1;
    end

    // Run enable rising or standby exit delays the acknowledge
    if ((clock_run_enable && !state_reg.run_d) || standby_exit) begin
      state_next.settle = 1'b1;
    end

    if (cal_tick) begin
      // Buffer transfer on the next calendar clock
      if (state_reg.wr_pend && !wr_sec) begin
        state_next.sec = state_reg.sec_buf;
        state_next.wr_pend = 1'b0;
      end

      // Hold handshake
      if (state_reg.hold_req && !state_reg.hold_ack) begin
        if (state_reg.settle) begin
          state_next.settle = 1'b0;
        end else begin
          state_next.hold_ack = 1'b1;
        end
      end else begin
        state_next.settle = 1'b0;
      end
      if (!state_reg.hold_req && state_reg.hold_ack &&
          !state_reg.wr_pend) begin
        state_next.hold_ack = 1'b0;
      end

      // Match seen at one tick, flagged at the next
      state_next.match_seen = state_reg.alarm_match_enable && alarm_match;
      if (state_reg.match_seen && state_reg.alarm_match_enable) begin
        state_next.alarm_hit_flag = 1'b1;
        if (state_reg.alarm_irq_enable) begin
          state_next.irq = 1'b1;
        end
      end
    end

    // Apply kept overflow once counting may proceed
    if (state_reg.carry_pend && !wr_sec && !state_reg.wr_pend &&
        !freeze && clock_run_enable) begin
      state_next.sec = sec_inc;
      state_next.sec_carry = sec_wrap;
      state_next.carry_pend = presc_ovf;
    end

    if (periodic_event) begin
      state_next.periodic_hit_flag = 1'b1;
      state_next.irq = 1'b1;
    end

    if (trim_tick_event && state_reg.trim_tick_irq_enable) begin
      state_next.tit = 1'b1;
    end

    // Retention reset clears control state but not the seconds
    if (!rst_n) begin
      state_next.alarm_match_enable = CHS_CTRL_RESET[CHS_ALARM_MATCH_ENABLE_BIT];
      state_next.alarm_irq_enable = CHS_CTRL_RESET[CHS_ALARM_IRQ_ENABLE_BIT];
      state_next.trim_tick_irq_enable = CHS_CTRL_RESET[CHS_TRIM_TICK_IRQ_ENABLE_BIT];
      state_next.alarm_hit_flag = CHS_CTRL_RESET[CHS_ALARM_HIT_FLAG_BIT];
      state_next.periodic_hit_flag = CHS_CTRL_RESET[CHS_PERIODIC_HIT_FLAG_BIT];
      state_next.hold_ack = CHS_CTRL_RESET[CHS_ACK_BIT];
      state_next.hold_req = CHS_CTRL_RESET[CHS_REQ_BIT];
      state_next.sec = state_reg.sec;
      state_next.sec_buf = state_reg.sec_buf;
      state_next.wr_pend = 1'b0;
      state_next.carry_pend = 1'b0;
      state_next.match_seen = 1'b0;
      state_next.settle = 1'b0;
      state_next.run_d = 1'b0;
      state_next.irq = 1'b0;
      state_next.tit = 1'b0;
      state_next.sec_carry = 1'b0;
      state_next.rdata = 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (ce || !rst_n) begin
      state_reg <= state_next;
    end
  end

  assign bus_rdata = state_reg.rdata;
  assign calendar_irq = state_reg.irq;
  assign trim_tick_irq = state_reg.tit;
  assign hold_ack_flag = state_reg.hold_ack;
  assign sec_value = state_reg.sec;
  assign sec_carry = state_reg.sec_carry;

endmodule // chs_calendar_ctrl
`default_nettype wire

/* File: rtl/chs_pkg.sv */
// Constants and state types for the calendar hold/alarm/seconds slice
// Functional notes
// - Alarm matches count only while alarm_match_enable is set.
// - Alarm match raises calendar_irq only when alarm_irq_enable is set.
// - trim_tick_irq is issued only while trim_tick_irq_enable is set.
// - alarm_hit_flag sets one calendar clock after a detected match.
// - Writing 0 clears alarm_hit_flag or periodic_hit_flag; writing 1 keeps it.
// - periodic_hit_flag sets on every constant-period interrupt.
// - hold_request freezes the seconds counter; clearing it resumes counting.
// - hold_ack_flag shows that the hold took effect.
// - hold_ack_flag sets within one calendar clock, two after run or standby.
// - hold_ack_flag stays set until a pending counter write completes.
// - Prescaler overflow during hold is kept and applied after release.
// - A seconds write during hold discards the kept overflow.
// - Any seconds write clears the 16-bit prescaler.
// - Seconds count BCD 00..59, top bit zero, stepping on prescaler overflow.
// - Seconds writes go to a buffer, reach the counter within two clocks.
// - Control register clears to zero only on the retention reset.
// - Seconds counter is not initialised by reset.
// - Alarm and periodic share calendar_irq; flags tell the cause.
// - clock_run_enable starts and stops calendar counting.
package chs_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [19:0] CHS_SEC_ADDR = 20'hfff92;
  localparam logic [19:0] CHS_CTRL_ADDR = 20'hfff9e;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int CHS_ALARM_MATCH_ENABLE_BIT = 7;
  localparam int CHS_ALARM_IRQ_ENABLE_BIT = 6;
  localparam int CHS_TRIM_TICK_IRQ_ENABLE_BIT = 5;
  localparam int CHS_ALARM_HIT_FLAG_BIT = 4;
  localparam int CHS_PERIODIC_HIT_FLAG_BIT = 3;
  localparam int CHS_ACK_BIT = 1;
  localparam int CHS_REQ_BIT = 0;
  localparam logic [7:0] CHS_CTRL_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Seconds counter
  // ---------------------------------------------------------------
  localparam logic [3:0] CHS_UNITS_MAX = 4'h9;
  localparam logic [2:0] CHS_TENS_MAX = 3'h5;
  localparam logic [15:0] CHS_PRESC_MAX = 16'hffff;

  // ---------------------------------------------------------------
  // Timing in calendar clock ticks
  // ---------------------------------------------------------------
  localparam int CHS_ACK_TICKS = 1;
  localparam int CHS_ACK_TICKS_SLOW = 2;
  localparam int CHS_WR_XFER_TICKS = 2;

  typedef struct packed {
    logic alarm_match_enable;
    logic alarm_irq_enable;
    logic trim_tick_irq_enable;
    logic alarm_hit_flag;
    logic periodic_hit_flag;
    logic hold_req;
    logic hold_ack;
    logic [6:0] sec;
    logic [6:0] sec_buf;
    logic wr_pend;
    logic carry_pend;
    logic match_seen;
    logic settle;
    logic run_d;
    logic irq;
    logic tit;
    logic sec_carry;
    logic [7:0] rdata;
  } chs_state_type;

  typedef struct packed {
    logic [15:0] count;
    logic ovf;
  } chs_presc_type;

endpackage

/* File: rtl/chs_prescaler.sv */
// Run-gated, clearable 16-bit prescaler feeding the seconds counter
`timescale 1ns/1ps
`default_nettype none
module chs_prescaler
  import chs_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Retention reset, low
  input wire logic ce, // Clock enable
  input wire logic tick, // Calendar clock pulse
  input wire logic run, // Counting enabled
  input wire logic clear, // Clear to zero
  output logic ovf // Overflow pulse
);

  chs_presc_type state_reg;
  chs_presc_type state_next;

  always_comb begin
    state_next = state_reg;
    state_next.ovf = 1'b0;
    if (!rst_n) begin
      state_next = '0;
    end else if (clear) begin
      state_next.count = '0;
    end else if (tick && run) begin
      state_next.count = state_reg.count + 16'h0001;
      state_next.ovf = (state_reg.count == CHS_PRESC_MAX);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (ce || !rst_n) begin
      state_reg <= state_next;
    end
  end

  assign ovf = state_reg.ovf;

endmodule // chs_prescaler
`default_nettype wire

/* File: tb/chs_calendar_ctrl_assertions.sv */
// Port checker of the calendar control slice
`timescale 1ns/1ps
`default_nettype none
module chs_calendar_ctrl_assertions
  import chs_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Reset
  input wire logic ce, // Enable
  input wire logic cal_tick, // Tick
  input wire logic clock_run_enable, // Run
  input wire logic standby_exit, // Wake
  input wire logic alarm_match, // Match
  input wire logic periodic_event, // Period
  input wire logic trim_tick_event, // Trim
  input wire logic [19:0] bus_addr, // Address
  input wire logic bus_wr, // Write
  input wire logic bus_rd, // Read
  input wire logic [7:0] bus_wdata, // Wdata
  input wire logic [7:0] bus_rdata, // Rdata
  input wire logic calendar_irq, // Irq
  input wire logic trim_tick_irq, // Trim irq
  input wire logic hold_ack_flag, // Ack
  input wire logic [6:0] sec_value, // Seconds
  input wire logic sec_carry // Wrap
);
  // --------
  // Port relations
  // --------
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  a_trim_cause: assert property (
    trim_tick_irq |-> $past(trim_tick_event)) else $error("stray trim irq");
  a_irq_cause: assert property (
    calendar_irq |-> $past(periodic_event) || $past(cal_tick)
      || $past(cal_tick, 2)) else $error("stray calendar irq");
  a_ack_rise: assert property (
    $rose(hold_ack_flag) |-> $past(cal_tick)) else $error("ack off tick");
  a_ack_fall: assert property (
    $fell(hold_ack_flag) |-> $past(cal_tick)) else $error("ack drop off tick");
  a_sec_wrap: assert property (
    sec_carry |-> sec_value == 7'h00 && ($past(sec_value) == 7'h59
      || $past(sec_value, 2) == 7'h59)) else $error("bad seconds wrap");
  a_rd_unmapped: assert property (
    ce && bus_rd && bus_addr != CHS_SEC_ADDR && bus_addr != CHS_CTRL_ADDR
      |=> bus_rdata == 8'h00) else $error("unmapped read not zero");
  a_ctrl_bit2: assert property (
    ce && bus_rd && bus_addr == CHS_CTRL_ADDR |=> !bus_rdata[2])
    else $error("control bit 2 set");
  a_sec_bit7: assert property (
    ce && bus_rd && bus_addr == CHS_SEC_ADDR |=> !bus_rdata[7])
    else $error("seconds bit 7 set");
  a_ack_read: assert property (
    ce && bus_rd && bus_addr == CHS_CTRL_ADDR
      |=> bus_rdata[CHS_ACK_BIT] == $past(hold_ack_flag))
    else $error("ack bit differs");
endmodule // chs_calendar_ctrl_assertions
bind chs_calendar_ctrl chs_calendar_ctrl_assertions chk_u (
  .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .cal_tick(cal_tick),
  .clock_run_enable(clock_run_enable), .standby_exit(standby_exit),
  .alarm_match(alarm_match), .periodic_event(periodic_event),
  .trim_tick_event(trim_tick_event), .bus_addr(bus_addr), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
  .calendar_irq(calendar_irq), .trim_tick_irq(trim_tick_irq),
  .hold_ack_flag(hold_ack_flag), .sec_value(sec_value), .sec_carry(sec_carry)
);
`default_nettype wire

/* File: tb/test_chs_calendar_ctrl.sv */
// Directed bench of the calendar control slice
`timescale 1ns/1ps
`default_nettype none
module test_chs_calendar_ctrl
  import chs_pkg::*;
;
  logic clk_sys, rst_n, ce, cal_tick, clock_run_enable, standby_exit;
  logic alarm_match, periodic_event, trim_tick_event, bus_wr, bus_rd;
  logic calendar_irq, trim_tick_irq, hold_ack_flag, sec_carry;
  logic [19:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata;
  logic [6:0] sec_value;
  logic [7:0] acfg [3] = '{8'hc0, 8'h40, 8'h80};
  logic [7:0] aexp [3] = '{8'hd0, 8'h40, 8'h90};
  int n_errors = 0, tests_run = 0, n_irq = 0, n_trim = 0, n_carry = 0;
  int tper = 4, tdiv = 0, cyc = 0, base = 0;
  chs_calendar_ctrl dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .cal_tick(cal_tick),
    .clock_run_enable(clock_run_enable), .standby_exit(standby_exit),
    .alarm_match(alarm_match), .periodic_event(periodic_event),
    .trim_tick_event(trim_tick_event), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .calendar_irq(calendar_irq), .trim_tick_irq(trim_tick_irq),
    .hold_ack_flag(hold_ack_flag), .sec_value(sec_value), .sec_carry(sec_carry)
  );
  // --------
  // Clock, calendar tick, event tallies
  // --------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    tdiv <= (tdiv + 1) % tper;
    cal_tick <= (tdiv == 0);
    cyc <= cyc + 1;
    n_irq <= n_irq + int'(calendar_irq === 1'b1);
    n_trim <= n_trim + int'(trim_tick_irq === 1'b1);
    n_carry <= n_carry + int'(sec_carry === 1'b1);
    if (cyc == 70000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic chk(input string name, input logic [7:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [19:0] a, input logic [7:0] e, input string n);
    @(posedge clk_sys);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1;
    chk(n, e, bus_rdata);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // --------
  // Test sequence
  // --------
  initial begin
    {rst_n, standby_exit, alarm_match, periodic_event} = 4'h0;
    {trim_tick_event, bus_wr, bus_rd, cal_tick} = 4'h0;
    {ce, clock_run_enable} = 2'h3;
    bus_addr = 20'h00000;
    bus_wdata = 8'h00;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(CHS_CTRL_ADDR, 8'h00, "ctrl after reset");
    $display("test reset done");
    wr(CHS_CTRL_ADDR, 8'h01);
    repeat (12) @(posedge clk_sys);
    rd(CHS_CTRL_ADDR, 8'h03, "hold ack");
    wr(CHS_SEC_ADDR, 8'ha5);
    repeat (12) @(posedge clk_sys);
    rd(CHS_SEC_ADDR, 8'h25, "held seconds");
    chk("sec value", 8'h25, {1'b0, sec_value});
    wr(CHS_CTRL_ADDR, 8'h05);
    rd(CHS_CTRL_ADDR, 8'h03, "ctrl bit2");
    wr(CHS_CTRL_ADDR, 8'h00);
    repeat (12) @(posedge clk_sys);
    rd(CHS_CTRL_ADDR, 8'h00, "hold release");
    $display("test hold done");
    base = n_irq;
    @(posedge clk_sys);
    periodic_event <= 1'b1;
    @(posedge clk_sys);
    periodic_event <= 1'b0;
    rd(CHS_CTRL_ADDR, 8'h08, "periodic flag");
    chk("periodic irq", 8'h01, 8'(n_irq - base));
    wr(CHS_CTRL_ADDR, 8'h08);
    rd(CHS_CTRL_ADDR, 8'h08, "flag kept");
    wr(CHS_CTRL_ADDR, 8'h00);
    rd(CHS_CTRL_ADDR, 8'h00, "flag cleared");
    $display("test periodic done");
    for (int i = 0; i < 3; i++) begin
      base = n_irq;
      wr(CHS_CTRL_ADDR, acfg[i]);
      // One calendar tick sees the match
      alarm_match <= 1'b1;
      repeat (4) @(posedge clk_sys);
      alarm_match <= 1'b0;
      repeat (12) @(posedge clk_sys);
      rd(CHS_CTRL_ADDR, aexp[i], "alarm flag");
      chk("alarm irq", 8'(i == 0), 8'(n_irq - base));
      wr(CHS_CTRL_ADDR, 8'h00);
    end
    $display("test alarm done");
    for (int i = 0; i < 2; i++) begin
      base = n_trim;
      wr(CHS_CTRL_ADDR, 8'(i << 5));
      @(posedge clk_sys);
      trim_tick_event <= 1'b1;
      @(posedge clk_sys);
      trim_tick_event <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      chk("trim irq", 8'(i), 8'(n_trim - base));
    end
    $display("test trim done");
    wr(CHS_SEC_ADDR, 8'h59);
    tper = 1;
    base = n_carry;
    repeat (8) @(posedge clk_sys);
    #1;
    chk("sec loaded", 8'h59, {1'b0, sec_value});
    repeat (65540) @(posedge clk_sys);
    #1;
    chk("sec wrap", 8'h00, {1'b0, sec_value});
    chk("wrap pulse", 8'h01, 8'(n_carry - base));
    $display("test seconds done");
    complete_run();
  end
endmodule // test_chs_calendar_ctrl
`default_nettype wire
